// ==== src/fdce_core.sv ====
// execution-phase engine of the floppy disk controller with apb register access
//
// Design decisions made here: the register offsets and the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "fdce_defs.svh"
module fdce_core #(
  parameter int unsigned FM_SVC_CYC  = `FDCE_FM_SVC_NS * `FDCE_CLK_MHZ / 1000,
  parameter int unsigned MFM_SVC_CYC = `FDCE_MFM_SVC_NS * `FDCE_CLK_MHZ / 1000
) (
  input  wire logic                clock_i,
  input  wire logic                rst_n_i,
  input  wire logic                psel_i,
  input  wire logic                penable_i,
  input  wire logic                pwrite_i,
  input  wire logic [7:0]          paddr_i,
  input  wire logic [31:0]         pwdata_i,
  output logic      [31:0]         prdata_o,
  output logic                     pready_o,
  output logic                     pslverr_o,
  input  wire logic                index_i,
  input  wire logic                drive_ready_i,
  input  wire logic                drive_fault_i,
  input  wire logic                transfer_stop_i,
  input  wire logic                med_id_i,
  input  wire logic [31:0]         med_id_val_i,
  input  wire logic                med_id_crc_ok_i,
  input  wire logic                med_dam_i,
  input  wire logic                med_ddam_i,
  input  wire logic [7:0]          med_rd_byte_i,
  input  wire logic                med_rd_valid_i,
  input  wire logic                med_wr_tick_i,
  output logic                     med_wr_gate_o,
  output logic                     med_wr_valid_o,
  output logic [7:0]               med_wr_byte_o,
  output fdce_pkg::fdce_mark_e     med_wr_mark_o,
  output logic                     dma_req_o,
  output logic                     data_int_o,
  output logic                     busy_o
);
  import fdce_pkg::*;

  ////////////////////////////////////////////////////////////////////////////////
  // helpers
  function automatic logic [13:0] sec_bytes(input logic [7:0] code);
    return `FDCE_SEC_BASE << code[2:0];
  endfunction

  function automatic logic scan_ok(input fdce_op_e op, input logic [7:0] d,
                                   input logic [7:0] hb);
    if (d == `FDCE_MASK_BYTE || hb == `FDCE_MASK_BYTE) return 1'b1;
    case (op)
      OP_SCAN_LE: return d <= hb;
      OP_SCAN_HE: return d >= hb;
      default:    return d == hb;
    endcase
  endfunction

  function automatic fdce_q_s finish(input fdce_q_s s, input logic abn);
    fdce_q_s t;
    t = s;
    t.st = S_IDLE;
    t.gate = 1'b0;
    t.wv = 1'b0;
    t.hfull = 1'b0;
    t.st0[7:6] = abn ? `FDCE_ABN : `FDCE_NORM;
    return t;
  endfunction

  function automatic fdce_q_s end_id(input fdce_q_s s);
    fdce_q_s t;
    t = s;
    if (s.r != s.end_of_track_sector) begin
      t.r = s.r + 8'h01;
    end else begin
      t.r = `FDCE_FIRST_SEC;
      if (s.mt) t.h[0] = ~s.h[0];
      if (!s.mt || s.h[0]) t.c = s.c + 8'h01;
    end
    return t;
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // state
  fdce_q_s q;
  fdce_q_s next_q;

  logic        acc;
  logic        is_scan;
  logic        host_need;
  logic        req;
  logic        ovr;
  logic        idx_p;
  logic [13:0] size;
  logic        wtick;
  logic        wr_end;
  logic [15:0] lim;
  logic        hwr;

  assign acc       = psel_i & penable_i;
  assign hwr       = acc & pwrite_i & (paddr_i == `FDCE_A_DATA);
  assign is_scan   = q.op inside {OP_SCAN_EQ, OP_SCAN_LE, OP_SCAN_HE};
  assign size      = sec_bytes(q.n);
  assign wtick     = med_wr_tick_i & q.wv;
  assign wr_end    = (q.st == S_WR) & wtick & (q.cnt + 14'h0001 == size);
  assign idx_p     = q.ix2 & ~q.ix3;
  assign host_need = ~q.hfull & (((q.st == S_WR) & ~q.stopd) | (q.st == S_FID) |
                                 ((q.st == S_RD) & is_scan & ~q.stopd));
  assign req       = host_need | q.dfull;
  assign lim       = q.mfm ? 16'(MFM_SVC_CYC) : 16'(FM_SVC_CYC);
  assign ovr       = (q.st != S_IDLE) & req & (q.tmr >= lim);

  assign pready_o       = 1'b1;
  assign med_wr_gate_o  = q.gate;
  assign med_wr_valid_o = q.wv;
  assign med_wr_byte_o  = q.wbyte;
  assign med_wr_mark_o  = q.mark;
  assign dma_req_o      = q.dma & req;
  assign data_int_o     = ~q.dma & req;
  assign busy_o         = q.st != S_IDLE;

  ////////////////////////////////////////////////////////////////////////////////
  // apb read side
  always_comb begin
    prdata_o = 32'h0000_0000;
    pslverr_o = 1'b0;
    case (paddr_i)
      `FDCE_A_CMD:  prdata_o = {22'h0, q.dma, 1'b0, q.mt, q.mfm, q.skip, 1'b0, q.op};
      `FDCE_A_ID:   prdata_o = {q.n, q.r, q.h, q.c};
      `FDCE_A_PRM:  prdata_o = {q.gap, q.spt, q.step, q.end_of_track_sector};
      `FDCE_A_FILL: prdata_o = {24'h0, q.fill};
      `FDCE_A_DATA: prdata_o = {24'h0, q.dbuf};
      `FDCE_A_STAT: prdata_o = {5'h0, q.hfull, q.dfull, busy_o, q.st2, q.st1, q.st0};
      default:      pslverr_o = acc;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////////
  // next state
  always_comb begin
    logic v;
    logic start;
    next_q = q;
    v = q.wv;
    start = 1'b0;
    next_q.ix1 = index_i;
    next_q.ix2 = q.ix1;
    next_q.ix3 = q.ix2;
    next_q.rd1 = drive_ready_i;
    next_q.rd2 = q.rd1;
    next_q.ft1 = drive_fault_i;
    next_q.ft2 = q.ft1;
    next_q.tc1 = transfer_stop_i;
    next_q.tc2 = q.tc1;
    next_q.tmr = req ? q.tmr + 16'h0001 : 16'h0000;
    if (q.st != S_IDLE && q.tc2) next_q.stopd = 1'b1;
    // register writes
    if (acc && pwrite_i) begin
      case (paddr_i)
        `FDCE_A_CMD: if (q.st == S_IDLE) begin
          next_q.op   = fdce_op_e'(pwdata_i[`FDCE_CMD_OP]);
          next_q.skip = pwdata_i[`FDCE_CMD_SKIP];
          next_q.mfm  = pwdata_i[`FDCE_CMD_MFM];
          next_q.mt   = pwdata_i[`FDCE_CMD_MT];
          next_q.dma  = pwdata_i[`FDCE_CMD_DMA];
          start       = pwdata_i[`FDCE_CMD_START];
        end
        `FDCE_A_ID: if (q.st == S_IDLE) {next_q.n, next_q.r, next_q.h, next_q.c} = pwdata_i;
        `FDCE_A_PRM: if (q.st == S_IDLE) begin
          {next_q.gap, next_q.spt, next_q.step, next_q.end_of_track_sector} = pwdata_i;
        end
        `FDCE_A_FILL: if (q.st == S_IDLE) next_q.fill = pwdata_i[7:0];
        `FDCE_A_DATA: begin
          next_q.hbuf = pwdata_i[7:0];
          next_q.hfull = 1'b1;
          next_q.tmr = 16'h0000;
        end
        default: ;
      endcase
    end
    if (acc && !pwrite_i && paddr_i == `FDCE_A_DATA) begin
      next_q.dfull = 1'b0;
      next_q.tmr = 16'h0000;
    end
    // index pulses while busy
    if (q.st != S_IDLE && q.st != S_WIDX && idx_p) next_q.idx = 1'b1;
    if (ovr) begin
      next_q.st1[`FDCE_ST1_OR] = 1'b1;
      next_q = finish(next_q, 1'b1);
    end else if (q.st != S_IDLE && q.st != S_WIDX && idx_p && q.idx &&
                 (q.op == OP_FORMAT || q.st == S_SEEK || q.st == S_MARK)) begin
      case (q.op)
        OP_FORMAT: next_q = finish(next_q, 1'b0);
        OP_RDTRK, OP_RDID: begin
          if (!q.idseen) next_q.st1[`FDCE_ST1_MA] = 1'b1;
          if (!q.dseen) next_q.st1[`FDCE_ST1_ND] = 1'b1;
          next_q = finish(next_q, 1'b1);
        end
        default: begin
          next_q.st1[`FDCE_ST1_ND] = 1'b1;
          next_q = finish(next_q, 1'b1);
        end
      endcase
    end else if (is_scan && q.stopd && (q.st == S_SEEK || q.st == S_MARK)) begin
      next_q = finish(next_q, 1'b0);
    end else begin
      case (q.st)
        S_IDLE: if (start) begin
          next_q.st0 = 8'h00;
          next_q.st1 = 8'h00;
          next_q.st2 = 8'h00;
          next_q.idx = 1'b0;
          next_q.sec = 8'h00;
          next_q.idseen = 1'b0;
          next_q.dseen = 1'b0;
          next_q.stopd = 1'b0;
          next_q.hfull = 1'b0;
          next_q.dfull = 1'b0;
          next_q.last = 1'b0;
          next_q.cnt = 14'h0000;
          if (!q.rd2) begin
            next_q.st0[`FDCE_ST0_NR] = 1'b1;
            next_q = finish(next_q, 1'b1);
          end else if (next_q.mfm && q.n == 8'h00 && next_q.op != OP_RDID) begin
            next_q = finish(next_q, 1'b1);
          end else if (next_q.op == OP_RDTRK || next_q.op == OP_FORMAT) begin
            next_q.st = S_WIDX;
          end else begin
            next_q.st = S_SEEK;
          end
        end
        S_WIDX: if (idx_p) begin
          next_q.idx = 1'b1;
          next_q.st = (q.op == OP_FORMAT) ? S_FGAP : S_SEEK;
          next_q.gate = q.op == OP_FORMAT;
        end
        S_SEEK: if (med_id_i) begin
          if (med_id_crc_ok_i) next_q.idseen = 1'b1;
          case (q.op)
            OP_RDID: if (med_id_crc_ok_i) begin
              {next_q.n, next_q.r, next_q.h, next_q.c} = med_id_val_i;
              next_q = finish(next_q, 1'b0);
            end
            OP_RDTRK: begin
              next_q.idseen = 1'b1;
              if (med_id_val_i != {q.n, q.r, q.h, q.c}) next_q.st1[`FDCE_ST1_ND] = 1'b1;
              next_q.st = S_MARK;
            end
            default: if (!med_id_crc_ok_i) begin
              next_q.st1[`FDCE_ST1_DE] = 1'b1;
              next_q = finish(next_q, 1'b1);
            end else if (med_id_val_i == {q.n, q.r, q.h, q.c}) begin
              next_q.cnt = 14'h0000;
              if (q.op == OP_WRITE || q.op == OP_WRDEL) begin
                next_q.st = S_WR;
                next_q.gate = 1'b1;
              end else begin
                next_q.st = S_MARK;
              end
            end
          endcase
        end
        S_MARK: if (med_dam_i || med_ddam_i) begin
          next_q.dseen = 1'b1;
          next_q.cnt = 14'h0000;
          next_q.allok = 1'b1;
          next_q.st = S_RD;
          if (q.op == OP_RDDEL && med_dam_i) begin
            if (q.skip) begin
              next_q.r = q.r + 8'h01;
              next_q.st = S_SEEK;
            end else begin
              next_q.st2[`FDCE_ST2_CM] = 1'b1;
              next_q.last = 1'b1;
            end
          end else if (is_scan && med_ddam_i) begin
            next_q.st2[`FDCE_ST2_CM] = 1'b1;
            if (q.skip) begin
              next_q.r = q.r + q.step;
              next_q.st = S_SEEK;
            end else begin
              next_q.last = 1'b1;
            end
          end
        end
        S_RD: if (med_rd_valid_i) begin
          next_q.cnt = q.cnt + 14'h0001;
          if (is_scan) begin
            next_q.allok = q.allok & scan_ok(q.op, med_rd_byte_i, q.hbuf);
            next_q.hfull = hwr;
          end else begin
            next_q.dbuf = med_rd_byte_i;
            next_q.dfull = 1'b1;
          end
          if (is_scan && q.stopd) begin
            next_q = finish(next_q, 1'b0);
          end else if (q.cnt + 14'h0001 == size) begin
            next_q.st = S_SEEK;
            if (q.op == OP_RDTRK) begin
              next_q.sec = q.sec + 8'h01;
              if (q.sec + 8'h01 == q.end_of_track_sector) next_q = finish(next_q, 1'b0);
            end else if (is_scan) begin
              if (next_q.allok) begin
                next_q.st2[`FDCE_ST2_SH] = 1'b1;
                next_q = finish(next_q, 1'b0);
              end else if (q.last) begin
                next_q = finish(next_q, 1'b0);
              end else if (q.r == q.end_of_track_sector) begin
                next_q.st2[`FDCE_ST2_SN] = 1'b1;
                next_q = finish(next_q, 1'b0);
              end else begin
                next_q.r = q.r + q.step;
              end
            end else if (q.last || q.stopd) begin
              next_q = finish(end_id(next_q), 1'b0);
            end else if (q.r == q.end_of_track_sector) begin
              next_q.st1[`FDCE_ST1_EN] = 1'b1;
              next_q = finish(end_id(next_q), 1'b1);
            end else begin
              next_q.r = q.r + 8'h01;
            end
          end
        end
        S_WR: begin
          if (wtick) begin
            v = 1'b0;
            next_q.mark = MK_NONE;
            next_q.cnt = q.cnt + 14'h0001;
          end
          if (wr_end) begin
            next_q.gate = 1'b0;
            next_q.wv = 1'b0;
            if (q.ft2) begin
              next_q.st0[`FDCE_ST0_EC] = 1'b1;
              next_q = finish(next_q, 1'b1);
            end else if (q.stopd) begin
              next_q = finish(end_id(next_q), 1'b0);
            end else if (q.r == q.end_of_track_sector) begin
              next_q.st1[`FDCE_ST1_EN] = 1'b1;
              next_q = finish(end_id(next_q), 1'b1);
            end else begin
              next_q.r = q.r + 8'h01;
              next_q.st = S_SEEK;
            end
          end else if (!v && (q.stopd || q.hfull)) begin
            next_q.wv = 1'b1;
            next_q.wbyte = q.stopd ? 8'h00 : q.hbuf;
            next_q.hfull = q.stopd ? q.hfull : hwr;
            if (q.cnt == 14'h0000 && !wtick) begin
              next_q.mark = (q.op == OP_WRDEL) ? MK_DEL : MK_DATA;
            end
          end else begin
            next_q.wv = v;
          end
        end
        S_FGAP: begin
          if (wtick) begin
            v = 1'b0;
            next_q.cnt = q.cnt + 14'h0001;
          end
          if (wtick && q.cnt + 14'h0001 >= 14'(q.gap) && q.sec < q.spt) begin
            next_q.cnt = 14'h0000;
            next_q.st = S_FID;
          end
          next_q.wv = v | (q.cnt + 14'h0001 < 14'(q.gap)) | (q.sec >= q.spt);
          next_q.wbyte = `FDCE_GAP_BYTE;
          next_q.mark = MK_NONE;
          if (wtick && next_q.st == S_FID) next_q.wv = 1'b0;
        end
        S_FID: begin
          if (wtick) begin
            v = 1'b0;
            next_q.cnt = q.cnt + 14'h0001;
            next_q.mark = MK_NONE;
          end
          if (wtick && q.cnt + 14'h0001 == `FDCE_ID_BYTES) begin
            next_q.cnt = 14'h0000;
            next_q.st = S_FDAT;
            next_q.wv = 1'b0;
          end else if (!v && q.hfull) begin
            next_q.wv = 1'b1;
            next_q.wbyte = q.hbuf;
            next_q.hfull = hwr;
            next_q.mark = (next_q.cnt == 14'h0000) ? MK_ID : MK_NONE;
          end else begin
            next_q.wv = v;
          end
        end
        S_FDAT: begin
          if (wtick) next_q.cnt = q.cnt + 14'h0001;
          if (wtick && q.cnt + 14'h0001 == size) begin
            next_q.r = q.r + 8'h01;
            next_q.sec = q.sec + 8'h01;
            next_q.cnt = 14'h0000;
            next_q.st = S_FGAP;
            next_q.wv = 1'b0;
          end else begin
            next_q.wv = 1'b1;
            next_q.wbyte = q.fill;
            next_q.mark = (next_q.cnt == 14'h0000) ? MK_DATA : MK_NONE;
          end
        end
        default: next_q = finish(next_q, 1'b1);
      endcase
    end
  end

  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      q <= '0;
      q.st <= S_IDLE;
    end else begin
      q <= next_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!rst_n_i);

  sequence s_wr_stop_end;
    wr_end && q.stopd && !q.ft2;
  endsequence

  sequence s_start_cmd;
    q.st == S_IDLE && acc && pwrite_i && paddr_i == `FDCE_A_CMD && pwdata_i[`FDCE_CMD_START];
  endsequence

  early_end_a: assert property (s_wr_stop_end ##0 (q.r != q.end_of_track_sector) |=>
      q.r == $past(q.r) + 8'h01 && q.c == $past(q.c) && q.h == $past(q.h) && busy_o == 1'b0)
    else $error("early end id wrong");
  mt_wrap_a: assert property (s_wr_stop_end ##0 (q.r == q.end_of_track_sector && q.mt) |=>
      q.r == 8'h01 && q.h[0] != $past(q.h[0]))
    else $error("multi-track wrap wrong");
  wr_next_a: assert property (wr_end && !q.stopd && !q.ft2 && q.r != q.end_of_track_sector |=>
      q.st == S_SEEK && q.r == $past(q.r) + 8'h01)
    else $error("write did not advance sector");
  zero_fill_a: assert property (q.st == S_WR && q.stopd && !q.wv && !wr_end |=>
      q.wv && q.wbyte == 8'h00)
    else $error("stop fill not zero");
  id_crc_a: assert property (q.st == S_SEEK && med_id_i && !med_id_crc_ok_i &&
      q.op == OP_WRITE && !ovr && !(idx_p && q.idx) |=>
      q.st1[`FDCE_ST1_DE] && q.st0[7:6] == 2'h1 && q.st == S_IDLE)
    else $error("id crc not ended");
  overrun_a: assert property (ovr |=> q.st1[`FDCE_ST1_OR] && !busy_o)
    else $error("overrun missed");
  del_mark_a: assert property (q.st == S_WR && q.op == OP_WRDEL && q.wv && q.cnt == 14'h0000
      |-> q.mark == MK_DEL)
    else $error("deleted mark missing");
  fmt_req_a: assert property (q.st == S_FID && !q.hfull && q.dma |-> dma_req_o)
    else $error("format id request missing");
  fault_a: assert property (wr_end && q.ft2 |=> q.st0[`FDCE_ST0_EC] && q.st0[7:6] == 2'h1)
    else $error("fault not flagged");
  not_ready_a: assert property (s_start_cmd ##0 !q.rd2 |=>
      q.st == S_IDLE && q.st0[7:6] == 2'h1 [*2])
    else $error("not ready start not abnormal");
  mfm128_a: assert property (s_start_cmd ##0 (q.rd2 && pwdata_i[`FDCE_CMD_MFM] &&
      q.n == 8'h00 && pwdata_i[3:0] != 4'h4) |=> !busy_o)
    else $error("mfm 128 byte sector accepted");
  scan_hit_a: assert property (q.st == S_RD && is_scan && med_rd_valid_i && !q.stopd &&
      !ovr && !(idx_p && q.idx) && q.cnt + 14'h0001 == size && q.allok &&
      scan_ok(q.op, med_rd_byte_i, q.hbuf) |=> q.st2[`FDCE_ST2_SH] && !busy_o)
    else $error("scan hit not ended");
endmodule
`default_nettype wire

// ==== src/fdce_defs.svh ====
// register offsets, field positions and timing in ns and MHz of the floppy command engine
`ifndef FDCE_DEFS_SVH
`define FDCE_DEFS_SVH
`define FDCE_CLK_MHZ     200
`define FDCE_FM_SVC_NS   27000
`define FDCE_MFM_SVC_NS  13000
`define FDCE_A_CMD       8'h00
`define FDCE_A_ID        8'h04
`define FDCE_A_PRM       8'h08
`define FDCE_A_FILL      8'h0C
`define FDCE_A_DATA      8'h10
`define FDCE_A_STAT      8'h14
`define FDCE_CMD_OP      3:0
`define FDCE_CMD_SKIP    5
`define FDCE_CMD_MFM     6
`define FDCE_CMD_MT      7
`define FDCE_CMD_START   8
`define FDCE_CMD_DMA     9
`define FDCE_ST0_EC      4
`define FDCE_ST0_NR      3
`define FDCE_ST1_EN      7
`define FDCE_ST1_DE      5
`define FDCE_ST1_OR      4
`define FDCE_ST1_ND      2
`define FDCE_ST1_MA      0
`define FDCE_ST2_CM      6
`define FDCE_ST2_SH      3
`define FDCE_ST2_SN      2
`define FDCE_ABN         2'h1
`define FDCE_NORM        2'h0
`define FDCE_GAP_BYTE    8'h4E
`define FDCE_MASK_BYTE   8'hFF
`define FDCE_ID_BYTES    14'h0004
`define FDCE_SEC_BASE    14'h0080
`define FDCE_FIRST_SEC   8'h01
`endif

// ==== src/fdce_pkg.sv ====
// types of the floppy command engine
package fdce_pkg;
  typedef enum logic [3:0] {
    OP_WRITE = 4'h0, OP_WRDEL = 4'h1, OP_RDDEL = 4'h2, OP_RDTRK = 4'h3, OP_RDID = 4'h4,
    OP_FORMAT = 4'h5, OP_SCAN_EQ = 4'h6, OP_SCAN_LE = 4'h7, OP_SCAN_HE = 4'h8
  } fdce_op_e;
  typedef enum logic [8:0] {
    S_IDLE = 9'h001, S_WIDX = 9'h002, S_SEEK = 9'h004, S_MARK = 9'h008, S_WR = 9'h010,
    S_RD = 9'h020, S_FGAP = 9'h040, S_FID = 9'h080, S_FDAT = 9'h100
  } fdce_state_e;
  typedef enum logic [1:0] {
    MK_NONE = 2'h0, MK_DATA = 2'h1, MK_DEL = 2'h2, MK_ID = 2'h3
  } fdce_mark_e;
  typedef struct packed {
    fdce_state_e st;
    fdce_op_e    op;
    logic        mt, mfm, skip, dma;
    logic [7:0]  c, h, r, n, end_of_track_sector, step, spt, gap, fill;
    logic [7:0]  st0, st1, st2, hbuf, dbuf, wbyte, sec;
    fdce_mark_e  mark;
    logic        hfull, dfull, wv, gate, idx, stopd, idseen, dseen, allok, last;
    logic [13:0] cnt;
    logic [15:0] tmr;
    logic        ix1, ix2, ix3, rd1, rd2, ft1, ft2, tc1, tc2;
  } fdce_q_s;
endpackage

// ==== verification/fdce_media_model.sv ====
// media codec stand-in: id fields, data marks, read bytes, write ticks
`timescale 1ns/1ps
`default_nettype none
module fdce_media_model (
  input  wire logic  clock_i,
  input  wire logic  rst_n_i,
  input  wire logic  wr_valid_i,
  output logic       id_o,
  output logic [31:0] id_val_o,
  output logic       dam_o,
  output logic       rd_valid_o,
  output logic [7:0] rd_byte_o,
  output logic       tick_o,
  output logic       index_o
);
  logic [10:0] t;
  logic [7:0]  sec;
  logic        tq;
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      t <= 11'h000;
      sec <= 8'h01;
      tick_o <= 1'b0;
      tq <= 1'b0;
    end else begin
      t <= (t == 11'h44B) ? 11'h000 : t + 11'h001;
      if (t == 11'h44B) sec <= (sec == 8'h04) ? 8'h01 : sec + 8'h01;
      tick_o <= wr_valid_i & ~tick_o & ~tq;
      tq <= tick_o;
    end
  end
  assign index_o = (t == 11'h000) && (sec == 8'h01);
  assign id_o = (t == 11'h014);
  assign id_val_o = id_o ? {8'h00, sec, 16'h0000} : ~{8'h00, sec, 16'h0000};
  assign dam_o = (t == 11'h018);
  assign rd_valid_o = (t >= 11'h020) && (t < 11'h420) && (t[2:0] == 3'h0);
  assign rd_byte_o = rd_valid_o ? 8'h55 : 8'hAA;
endmodule
`default_nettype wire

// ==== verification/tb_floppy_disk_command_engine.sv ====
// apb bench of the floppy command engine
`timescale 1ns/1ps
`default_nettype none
module tb_floppy_disk_command_engine;
  import fdce_pkg::*;
  logic clock_i = 1'b0, rst_n_i = 1'b0, psel = 1'b0, pen = 1'b0, pwr = 1'b0, rerr;
  logic rdy = 1'b1, stop = 1'b0, prdy, perr, gate, wv, dreq, dint, busy, id, dam, rvm, tick, idx;
  logic crc = 1'b1, flt = 1'b0, del = 1'b0;
  logic [7:0]  pa = 8'h00, rb, wb;
  logic [31:0] pwd = 32'h0, prd, rv, idv;
  fdce_mark_e  mk, mks;
  int          bad_count = 0, compares = 0, tot, nz;
  logic [31:0] wc[2] = '{32'h100, 32'h181}, wp[2] = '{32'h105, 32'h101};
  logic [31:0] wi[2] = '{32'h20000, 32'h10100}, sc[4] = '{32'h106, 32'h106, 32'h107, 32'h108};
  logic [7:0]  sb[4] = '{8'hFF, 8'h54, 8'h56, 8'h56};
  logic [1:0]  wm[2] = '{2'h1, 2'h2}, se[4] = '{2'h2, 2'h1, 2'h2, 2'h1};
  logic [31:0] rc[4] = '{32'h102, 32'h103, 32'h104, 32'h305};
  logic [31:0] rp[4] = '{32'h105, 32'h102, 32'h105, 32'h03010101};
  logic [31:0] rm[4] = '{32'hFFFFFFFF, 32'hFFFFFFFF, 32'hFFF8FFFF, 32'hFFFFFFFF};
  logic [31:0] ri[4] = '{32'h20000, 32'h10000, 32'h0, 32'h20000};
  logic [31:0] rs[4] = '{32'h400000, 32'h400, 32'h0, 32'h0};
  int          rn[4] = '{1000, 1000, 1000, 4};
  always #2.5 clock_i = ~clock_i;
  fdce_core #(.FM_SVC_CYC(40), .MFM_SVC_CYC(40)) fdce_core_inst (.clock_i(clock_i),
    .rst_n_i(rst_n_i), .psel_i(psel), .penable_i(pen), .pwrite_i(pwr), .paddr_i(pa),
    .pwdata_i(pwd), .prdata_o(prd), .pready_o(prdy), .pslverr_o(perr), .index_i(idx),
    .drive_ready_i(rdy), .drive_fault_i(flt), .transfer_stop_i(stop), .med_id_i(id),
    .med_id_val_i(idv), .med_id_crc_ok_i(crc), .med_dam_i(dam & ~del), .med_ddam_i(dam & del),
    .med_rd_byte_i(rb), .med_rd_valid_i(rvm), .med_wr_tick_i(tick), .med_wr_gate_o(gate),
    .med_wr_valid_o(wv), .med_wr_byte_o(wb), .med_wr_mark_o(mk), .dma_req_o(dreq),
    .data_int_o(dint), .busy_o(busy));
  fdce_media_model fdce_media_model_inst (.clock_i(clock_i), .rst_n_i(rst_n_i),
    .wr_valid_i(wv), .id_o(id), .id_val_o(idv), .dam_o(dam), .rd_valid_o(rvm),
    .rd_byte_o(rb), .tick_o(tick), .index_o(idx));
  always @(posedge clock_i) if (tick === 1'b1 && wv === 1'b1) begin
    tot <= tot + 1;
    if (wb !== 8'h00) nz <= nz + 1;
    if (mk !== MK_NONE) mks <= mk;
  end
  task automatic finish_test();
    $display("compares %0d mismatches %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1; pwr <= w; pa <= a; pwd <= d;
    @(posedge clock_i);
    pen <= 1'b1;
    do begin
      @(posedge clock_i);
      n++;
    end while (prdy !== 1'b1 && n < 50);
    rv = prd;
    rerr = perr;
    psel <= 1'b0; pen <= 1'b0;
    @(posedge clock_i);
    if (n >= 50) begin bad_count++; finish_test(); end
  endtask
  task automatic start(input logic [31:0] c, input logic [31:0] p);
    apb(1'b1, 8'h04, 32'h00010000);
    apb(1'b1, 8'h08, p);
    apb(1'b1, 8'h00, c);
  endtask
  task automatic feed(input logic rd, input logic [7:0] v, input int nmax);
    int k, n;
    k = 0; n = 0;
    while (busy !== 1'b0 && n < 12000) begin
      if ((dint === 1'b1 || dreq === 1'b1) && k < nmax) begin
        apb(!rd, 8'h10, {24'h0, v});
        if (rd) chk(rv, 32'h55);
        k++;
      end else begin
        @(posedge clock_i);
        n++;
      end
      if (k == nmax && nmax != 0) stop <= 1'b1;
    end
    stop <= 1'b0;
    if (n >= 12000) begin bad_count++; finish_test(); end
  endtask
  initial begin
    repeat (20) @(posedge clock_i);
    rst_n_i <= 1'b1;
    repeat (3) @(posedge clock_i);
    apb(1'b0, 8'h14, 32'h0); chk(rv, 32'h0);
    apb(1'b0, 8'h18, 32'h0); chk({rv[31:1], rerr}, 32'h1);
    for (int i = 0; i < 2; i++) begin
      tot = 0; nz = 0;
      start(wc[i], wp[i]);
      feed(1'b0, 8'hA5, 3);
      apb(1'b0, 8'h04, 32'h0); chk(rv, wi[i]);
      chk({tot[7:0], nz[7:0], 14'h0, mks}, {8'h80, 8'h03, 14'h0, wm[i]});
      apb(1'b0, 8'h14, 32'h0); chk({24'h0, rv[7:6], 6'h0}, 32'h0);
    end
    for (int i = 0; i < 2; i++) begin
      crc <= i[0];
      flt <= i[0];
      repeat (3) @(posedge clock_i);
      start(32'h100, 32'h105);
      feed(1'b0, 8'hA5, 3);
      apb(1'b0, 8'h14, 32'h0); chk(rv & 32'h20D0, i ? 32'h50 : 32'h2040);
    end
    flt <= 1'b0;
    start(32'h100, 32'h105);
    feed(1'b0, 8'h00, 0);
    apb(1'b0, 8'h14, 32'h0); chk(rv & 32'h10C0, 32'h1040);
    rdy <= 1'b0;
    repeat (3) @(posedge clock_i);
    start(32'h100, 32'h105);
    feed(1'b0, 8'h00, 0);
    apb(1'b0, 8'h14, 32'h0); chk(rv & 32'hC8, 32'h48);
    rdy <= 1'b1;
    repeat (3) @(posedge clock_i);
    for (int i = 0; i < 4; i++) begin
      start(sc[i], 32'h101);
      feed(1'b0, sb[i], 1000);
      apb(1'b0, 8'h14, 32'h0); chk({30'h0, rv[19:18]}, {30'h0, se[i]});
    end
    del <= 1'b1;
    start(32'h106, 32'h105);
    feed(1'b0, 8'h54, 1000);
    apb(1'b0, 8'h14, 32'h0); chk(rv & 32'h004C00C0, 32'h00400000);
    del <= 1'b0;
    start(32'h140, 32'h105);
    apb(1'b0, 8'h14, 32'h0); chk(rv & 32'h010000C0, 32'h40);
    for (int i = 0; i < 4; i++) begin
      start(rc[i], rp[i]);
      feed(rc[i][3:0] != 4'h5, 8'h5A, rn[i]);
      apb(1'b0, 8'h04, 32'h0); chk(rv & rm[i], ri[i]);
      apb(1'b0, 8'h14, 32'h0); chk(rv & 32'h00FFFFC0, rs[i]);
    end
    finish_test();
  end
endmodule
`default_nettype wire
